// file: inc/pcp_pkg.sv
// ============================================================
// Port pin control constants
// ============================================================
package pcp_pkg;

   typedef logic [7:0]  pcp_byte_type;
   typedef logic [15:0] pcp_addr_type;

   // Port order in every table: ports 0, 1, 2, 3, 6, 12
   localparam int PCP_NPORT  = 6;
   localparam int PCP_PORT2  = 2;
   localparam int PCP_PORT12 = 5;

   // ============================================================
   // Register addresses
   // ============================================================
   localparam pcp_addr_type PCP_LATCH_ADDR [PCP_NPORT] = '{
      16'hff00, 16'hff01, 16'hff02, 16'hff03, 16'hff06, 16'hff0c};
   localparam pcp_addr_type PCP_DIR_ADDR [PCP_NPORT] = '{
      16'hff20, 16'hff21, 16'hff22, 16'hff23, 16'hff26, 16'hff2c};
   localparam pcp_addr_type PCP_PU_ADDR [PCP_NPORT] = '{
      16'hff30, 16'hff31, 16'h0000, 16'hff33, 16'h0000, 16'hff3c};
   localparam pcp_addr_type PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR   = 16'hff2f;
   localparam pcp_addr_type PCP_OSCSEL_ADDR = 16'hff9f;

   // ============================================================
   // Field layouts and masks
   // ============================================================
   localparam pcp_byte_type PCP_PORT_MASK [PCP_NPORT] = '{
      8'h03, 8'hff, 8'h1f, 8'h0f, 8'h07, 8'h1f};
   localparam pcp_byte_type PCP_PU_MASK [PCP_NPORT] = '{
      8'h03, 8'hff, 8'h00, 8'h0f, 8'h00, 8'h01};
   localparam pcp_byte_type PCP_OSCSEL_MASK  = 8'hf1;
   localparam int           PCP_OSC_MAIN_BIT = 6;
   localparam int           PCP_OSC_SUB_BIT  = 4;
   localparam int           PCP_ANALOG_DIGITAL_PIN_SELECT_W       = 3;
   localparam int           PCP_ANA_PINS     = 5;
   localparam logic [2:0]   PCP_ANALOG_DIGITAL_PIN_SELECT_MAX     = 3'h5;

   // ============================================================
   // Reset values
   // ============================================================
   localparam pcp_byte_type PCP_LATCH_RST  = 8'h00;
   localparam pcp_byte_type PCP_DIR_RST    = 8'hff;
   localparam pcp_byte_type PCP_PU_RST     = 8'h00;
   localparam logic [2:0]   PCP_ANALOG_DIGITAL_PIN_SELECT_RST   = 3'h0;
   localparam pcp_byte_type PCP_OSCSEL_RST = 8'h00;

endpackage

// file: inc/pcp_slice_if.sv
`timescale 1ns/1ps
// ============================================================
// Link between the control top and one port slice
// ============================================================
interface pcp_slice_if;
   logic [7:0] wdata;
   logic       wrLatch;
   logic       wrDir;
   logic       wrPu;
   logic [7:0] pinIn;
   logic [7:0] effIn;
   logic [7:0] latch;
   logic [7:0] dir;
   logic [7:0] pu;
   logic [7:0] readMix;

   modport ctrl (
      output wdata, wrLatch, wrDir, wrPu, pinIn, effIn,
      input  latch, dir, pu, readMix
   );
   modport slice (
      input  wdata, wrLatch, wrDir, wrPu, pinIn, effIn,
      output latch, dir, pu, readMix
   );
endinterface

// file: testbench/pcp_pin_model.sv
`timescale 1ns/1ps
// ============================================================
// External pins: driver, outside source, pull-up or float
// ============================================================
module pcp_pin_model (
   // Clock
   input wire logic        mclk,
   // Device side
   input wire logic [47:0] pinOut,
   input wire logic [47:0] pinOutEnN,
   input wire logic [47:0] pullUp,
   // Outside sources
   input wire logic [47:0] extEn,
   input wire logic [47:0] extVal,
   output logic     [47:0] pinLevel
);
   logic [47:0] floatPat = 48'h5a5a5a5a5a5a;
   // Floating pins wander so a stale level never passes for a real one
   always_ff @(posedge mclk) begin
      floatPat <= ~floatPat;
   end
   // Driven pins show the latch; released pins take source or pull-up
   assign pinLevel = (~pinOutEnN & pinOut)
      | (pinOutEnN & extEn & extVal)
      | (pinOutEnN & ~extEn & (pullUp | floatPat));
endmodule

// file: testbench/pcp_port_control_sva.sv
`timescale 1ns/1ps
// ============================================================
// Port control checker
// ============================================================
module pcp_port_control_sva
   import pcp_pkg::*;
(
   // Clock and reset
   input wire logic                    mclk,
   input wire logic                    reset,
   // CPU access
   input wire logic [15:0]             cpuAddr,
   input wire logic                    cpuWrite,
   input wire logic                    cpuRead,
   input wire logic                    cpuBitOp,
   input wire logic [2:0]              cpuBitSel,
   input wire logic                    cpuBitVal,
   input wire logic [7:0]              cpuWdata,
   input wire logic [7:0]              cpuRdata_q,
   input wire logic                    cpuWait_q,
   // Pins
   input wire logic [PCP_NPORT*8-1:0]  pinIn,
   input wire logic [PCP_NPORT*8-1:0]  altOutEn,
   input wire logic [PCP_NPORT*8-1:0]  altOutData,
   input wire logic [PCP_NPORT*8-1:0]  pinOut_q,
   input wire logic [PCP_NPORT*8-1:0]  pinOutEnN_q,
   input wire logic [PCP_NPORT*8-1:0]  pullUpEn_q,
   // Converter and clock side
   input wire logic [PCP_ANA_PINS-1:0] analogSel_q,
   input wire logic                    oscMainMode_q,
   input wire logic                    oscSubMode_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_wr(a);
      cpuWrite && !cpuBitOp && cpuAddr == a;
   endsequence
   property p_wait;
      cpuWrite && cpuAddr == 16'hff2f |=> cpuWait_q;
   endproperty
   a_wait: assert property (p_wait) else $error("wait missing");
   property p_nowait;
      !(cpuWrite && cpuAddr == 16'hff2f) |=> !cpuWait_q;
   endproperty
   a_nowait: assert property (p_nowait) else $error("stray wait");
   property p_sel;
      logic [2:0] k;
      (s_wr(16'hff2f), k = cpuWdata[2:0]) |-> ##2
         analogSel_q == ((k >= 3'h5) ? 5'h00 : 5'(5'h1f << k));
   endproperty
   a_sel: assert property (p_sel) else $error("analog select");
   property p_dir;
      logic [7:0] d;
      (s_wr(16'hff21), d = cpuWdata) |-> ##2 pinOutEnN_q[15:8] == d;
   endproperty
   a_dir: assert property (p_dir) else $error("driver enable");
   property p_latch;
      logic [7:0] d;
      (s_wr(16'hff01), d = cpuWdata) |-> ##2
         ((pinOut_q[15:8] ^ d) & ~$past(altOutEn[15:8])) == 8'h00;
   endproperty
   a_latch: assert property (p_latch) else $error("latch out");
   property p_pu_drv;
      (pullUpEn_q & ~pinOutEnN_q) == '0;
   endproperty
   a_pu_drv: assert property (p_pu_drv) else $error("pull-up on output");
   property p_pu_alt;
      1'b1 |=> (pullUpEn_q & $past(altOutEn)) == '0;
   endproperty
   a_pu_alt: assert property (p_pu_alt) else $error("pull-up on alt");
   property p_rst;
      $fell(reset) |-> pullUpEn_q == '0 && analogSel_q == 5'h1f
         && (&pinOutEnN_q) && pinOut_q == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_osc;
      oscMainMode_q && $past(oscMainMode_q) |->
         (&pinOutEnN_q[42:41]) && pullUpEn_q[42:41] == 2'h0;
   endproperty
   a_osc: assert property (p_osc) else $error("osc pins driven");
   property p_seltop;
      cpuRead && cpuAddr == 16'hff2f |=> cpuRdata_q[7:3] == 5'h00;
   endproperty
   a_seltop: assert property (p_seltop) else $error("selector top");
endmodule

bind pcp_port_control pcp_port_control_sva u_sva (
   .mclk(mclk), .reset(reset), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
   .cpuRead(cpuRead), .cpuBitOp(cpuBitOp), .cpuBitSel(cpuBitSel),
   .cpuBitVal(cpuBitVal), .cpuWdata(cpuWdata), .cpuRdata_q(cpuRdata_q),
   .cpuWait_q(cpuWait_q), .pinIn(pinIn), .altOutEn(altOutEn),
   .altOutData(altOutData), .pinOut_q(pinOut_q),
   .pinOutEnN_q(pinOutEnN_q), .pullUpEn_q(pullUpEn_q),
   .analogSel_q(analogSel_q), .oscMainMode_q(oscMainMode_q),
   .oscSubMode_q(oscSubMode_q));

// file: testbench/pcp_port_control_tb.sv
`timescale 1ns/1ps
// ============================================================
// Port pin control bench
// ============================================================
module pcp_port_control_tb;
   import pcp_pkg::*;
   logic        mclk, reset, cpuWrite, cpuRead, cpuBitOp, cpuBitVal;
   logic [15:0] cpuAddr;
   logic [2:0]  cpuBitSel;
   logic [7:0]  cpuWdata, cpuRdata_q, dir, lat, pu, d, q, m, e;
   logic [47:0] pinIn, altOutEn, altOutData, extEn, extVal;
   logic [47:0] pinOut_q, pinOutEnN_q, pullUpEn_q;
   logic [4:0]  analogSel_q;
   logic        cpuWait_q, oscMainMode_q, oscSubMode_q, w;
   integer      failures, checks, seed, i;

   pcp_port_control u_dut (
      .mclk(mclk), .reset(reset), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
      .cpuRead(cpuRead), .cpuBitOp(cpuBitOp), .cpuBitSel(cpuBitSel),
      .cpuBitVal(cpuBitVal), .cpuWdata(cpuWdata), .cpuRdata_q(cpuRdata_q),
      .cpuWait_q(cpuWait_q), .pinIn(pinIn), .altOutEn(altOutEn),
      .altOutData(altOutData), .pinOut_q(pinOut_q),
      .pinOutEnN_q(pinOutEnN_q), .pullUpEn_q(pullUpEn_q),
      .analogSel_q(analogSel_q), .oscMainMode_q(oscMainMode_q),
      .oscSubMode_q(oscSubMode_q));
   pcp_pin_model u_pins (
      .mclk(mclk), .pinOut(pinOut_q), .pinOutEnN(pinOutEnN_q),
      .pullUp(pullUpEn_q), .extEn(extEn), .extVal(extVal),
      .pinLevel(pinIn));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic logic [4:0] expSel(input logic [2:0] k);
      return (k >= 3'h5) ? 5'h00 : 5'(5'h1f << k);
   endfunction

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One access, then one idle cycle so pin outputs have settled
   task automatic acc(input logic [15:0] a, input logic [7:0] dv,
                      input logic bop, input logic rd);
      @(negedge mclk);
      cpuAddr = a;
      cpuWdata = dv;
      cpuBitOp = bop;
      cpuBitSel = dv[2:0];
      cpuBitVal = dv[3];
      cpuWrite = !rd;
      cpuRead = rd;
      @(negedge mclk);
      cpuWrite = 1'b0;
      cpuRead = 1'b0;
      q = cpuRdata_q;
      w = cpuWait_q;
      @(negedge mclk);
   endtask

   task automatic summarize;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      summarize();
   end

   initial begin
      seed = 49;
      failures = 0;
      checks = 0;
      reset = 1'b1;
      {cpuWrite, cpuRead, cpuBitOp, cpuBitVal} = 4'h0;
      cpuAddr = 16'h0000;
      cpuBitSel = 3'h0;
      cpuWdata = 8'h00;
      {altOutEn, altOutData, extEn, extVal} = '0;
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      for (i = 0; i < PCP_NPORT; i++) begin
         acc(PCP_DIR_ADDR[i], 8'h00, 1'b0, 1'b1);
         chk(q, 8'hff);
         if (PCP_PU_MASK[i] != 8'h00) begin
            acc(PCP_PU_ADDR[i], 8'h00, 1'b0, 1'b1);
            chk(q, 8'h00);
         end
      end
      acc(PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR, 8'h00, 1'b0, 1'b1);
      chk(q, 8'h00);
      acc(PCP_OSCSEL_ADDR, 8'h00, 1'b0, 1'b1);
      chk(q, 8'h00);
      acc(16'hff10, 8'h00, 1'b0, 1'b1);
      chk(q, 8'h00);
      chk(analogSel_q, 5'h1f);
      $display("test reset done");
      repeat (40) begin
         dir = 8'($random(seed));
         lat = 8'($random(seed));
         pu = 8'($random(seed));
         extEn[15:8] = 8'($random(seed));
         extVal[15:8] = 8'($random(seed));
         acc(16'hff21, dir, 1'b0, 1'b0);
         acc(16'hff01, lat, 1'b0, 1'b0);
         acc(16'hff31, pu, 1'b0, 1'b0);
         chk(pinOutEnN_q[15:8], dir);
         chk(pullUpEn_q[15:8], pu & dir);
         m = ~dir | extEn[15:8] | pu;
         e = (lat & ~dir) | (dir & extEn[15:8] & extVal[15:8])
            | (dir & ~extEn[15:8] & pu);
         acc(16'hff01, 8'h00, 1'b0, 1'b1);
         chk(q & m, e & m);
         chk(pinOut_q[15:8], lat);
         d = 8'($random(seed));
         acc(16'hff01, d, 1'b1, 1'b0);
         e[d[2:0]] = d[3];
         m[d[2:0]] = 1'b1;
         chk(pinOut_q[15:8] & m, e & m);
      end
      $display("test port random done");
      extEn = '0;
      acc(16'hff21, 8'hf0, 1'b0, 1'b0);
      acc(16'hff01, 8'h09, 1'b0, 1'b0);
      acc(16'hff31, 8'hff, 1'b0, 1'b0);
      chk(w, 1'b0);
      altOutEn[15:8] = 8'h0f;
      altOutData[15:8] = 8'h05;
      acc(16'hff31, 8'h03, 1'b1, 1'b0);
      chk(pullUpEn_q[15:8], 8'hf0);
      chk(pinOut_q[15:8], 8'h05);
      chk(pinOutEnN_q[15:8], 8'hf0);
      acc(16'hff31, 8'h00, 1'b0, 1'b1);
      chk(q, 8'hf7);
      altOutEn = '0;
      $display("test pull-up done");
      for (i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         d[2:0] = 3'(i);
         acc(PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR, d, 1'b0, 1'b0);
         chk(w, 1'b1);
         chk(analogSel_q, expSel(d[2:0]));
         acc(16'hff22, {3'h7, expSel(d[2:0])}, 1'b0, 1'b0);
         chk(w, 1'b0);
         chk(pinOutEnN_q[20:16], expSel(d[2:0]));
         acc(PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR, 8'h00, 1'b0, 1'b1);
         chk(q, {5'h00, d[2:0]});
      end
      acc(16'hff22, 8'hff, 1'b0, 1'b0);
      acc(PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR, 8'h01, 1'b1, 1'b0);
      acc(PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR, 8'h02, 1'b1, 1'b0);
      chk(analogSel_q, 5'h1e);
      $display("test selector done");
      acc(16'hff2c, 8'h00, 1'b0, 1'b0);
      acc(PCP_OSCSEL_ADDR, 8'h50, 1'b0, 1'b0);
      chk({oscMainMode_q, oscSubMode_q}, 2'h3);
      chk(pinOutEnN_q[44:40], 5'h1e);
      $display("test oscillator done");
      acc(16'hff01, 8'ha5, 1'b0, 1'b0);
      reset = 1'b1;
      @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
      chk(pinOut_q, '0);
      chk(pinOutEnN_q, '1);
      chk(oscMainMode_q, 1'b0);
      $display("test second reset done");
      summarize();
   end
endmodule

// file: verilog/pcp_port_control.sv
`timescale 1ns/1ps
// Function
// - Pull-up select 1 connects, 0 disconnects
// - Pull-up only on input-mode, non-alternate-output pins
// - Pull-up selects reset to 00H
// - Pull-up and selector accept bit, byte writes
// - Analog selector at FF2FH, resets to 00H
// - Selector k makes k lowest pins digital
// - Selector write inserts one wait cycle
// - Bit instruction rewrites the whole port byte
// - Output mode: latch written and driven
// - Input mode: latch written, pin unchanged
// - Reset clears every output latch
// - Output-mode read returns latch
// - Input-mode read returns pin level
// - Output-mode modify works on latch
// - Input-mode modify takes pin level
// - Oscillator pins leave port in clock modes
// - Direction 0 drives, 1 is input
// - Direction registers reset to FFH
// ============================================================
// Port pin control top
// ============================================================
module pcp_port_control
   import pcp_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     reset,
   // CPU memory access
   input  wire logic [15:0]              cpuAddr,
   input  wire logic                     cpuWrite,
   input  wire logic                     cpuRead,
   input  wire logic                     cpuBitOp,
   input  wire logic [2:0]               cpuBitSel,
   input  wire logic                     cpuBitVal,
   input  wire logic [7:0]               cpuWdata,
   output logic      [7:0]               cpuRdata_q,
   output logic                          cpuWait_q,
   // Pins and alternate-function peripherals
   input  wire logic [PCP_NPORT*8-1:0]   pinIn,
   input  wire logic [PCP_NPORT*8-1:0]   altOutEn,
   input  wire logic [PCP_NPORT*8-1:0]   altOutData,
   output logic      [PCP_NPORT*8-1:0]   pinOut_q,
   output logic      [PCP_NPORT*8-1:0]   pinOutEnN_q,
   output logic      [PCP_NPORT*8-1:0]   pullUpEn_q,
   // Converter and clock generator side
   output logic      [PCP_ANA_PINS-1:0]  analogSel_q,
   output logic                          oscMainMode_q,
   output logic                          oscSubMode_q
);

   // ============================================================
   // Declarations
   // ============================================================
   logic [PCP_ANALOG_DIGITAL_PIN_SELECT_W-1:0]   analog_digital_pin_select_q;
   logic [PCP_ANALOG_DIGITAL_PIN_SELECT_W-1:0]   analog_digital_pin_select_d;
   pcp_byte_type            oscSel_q;
   pcp_byte_type            oscSel_d;
   pcp_byte_type            cpuRdata_d;
   logic                    cpuWait_d;
   logic [PCP_NPORT*8-1:0]  pinOut_d;
   logic [PCP_NPORT*8-1:0]  pinOutEnN_d;
   logic [PCP_NPORT*8-1:0]  pullUpEn_d;
   logic [PCP_ANA_PINS-1:0] analogSel_d;
   logic                    oscMainMode_d;
   logic                    oscSubMode_d;
   logic [PCP_ANA_PINS-1:0] digMask;
   logic [PCP_ANALOG_DIGITAL_PIN_SELECT_W-1:0]   digCount;
   pcp_byte_type            forceIn [PCP_NPORT];
   pcp_byte_type            latchRd [PCP_NPORT];
   pcp_byte_type            dirRd   [PCP_NPORT];
   pcp_byte_type            puRd    [PCP_NPORT];
   logic                    hitAdpc;
   logic                    hitOsc;
   logic                    oscMain;
   logic                    oscSub;

   // Single-bit writes: read the byte, replace one bit, write back
   function automatic pcp_byte_type mergeBit(
      input pcp_byte_type base,
      input logic [2:0]   sel,
      input logic         val
   );
      pcp_byte_type res;
      res      = base;
      res[sel] = val;
      return res;
   endfunction

   assign hitAdpc = (cpuAddr == PCP_ANALOG_DIGITAL_PIN_SELECT_ADDR);
   assign hitOsc  = (cpuAddr == PCP_OSCSEL_ADDR);
   assign oscMain = oscSel_q[PCP_OSC_MAIN_BIT];
   assign oscSub  = oscSel_q[PCP_OSC_SUB_BIT];

   // ============================================================
   // Analog selector decode
   // ============================================================
   always_comb begin
      // Values six and seven act as all-digital
      if (analog_digital_pin_select_q > PCP_ANALOG_DIGITAL_PIN_SELECT_MAX) begin
         digCount = PCP_ANALOG_DIGITAL_PIN_SELECT_MAX;
      end else begin
         digCount = analog_digital_pin_select_q;
      end
      for (int b = 0; b < PCP_ANA_PINS; b++) begin
         digMask[b] = (3'(b) < digCount);
      end
      // A one marks a pin handed to the converter
      analogSel_d = ~digMask;
   end

   // ============================================================
   // Pin steering: analog and oscillator pins forced off
   // ============================================================
   always_comb begin
      // Clock-mode pins ignore direction and latch alike
      oscMainMode_d = oscMain;
      oscSubMode_d  = oscSub;
      for (int p = 0; p < PCP_NPORT; p++) begin
         forceIn[p] = 8'h00;
      end
      forceIn[PCP_PORT2]  = {3'h0, ~digMask};
      forceIn[PCP_PORT12] = {3'h0, oscSub, oscSub,
                             oscMain, oscMain, 1'b0};
   end

   // ============================================================
   // Per-port slices
   // ============================================================
   for (genvar i = 0; i < PCP_NPORT; i++) begin : g_port
      pcp_slice_if sl ();
      logic        hitL;
      logic        hitD;
      logic        hitU;
      logic [7:0]  alt;

      pcp_port_slice #(
         .PORT_MASK (PCP_PORT_MASK[i]),
         .PU_MASK   (PCP_PU_MASK[i])
      ) u_slice (
         .mclk  (mclk),
         .reset (reset),
         .bus   (sl.slice)
      );

      assign hitL = (cpuAddr == PCP_LATCH_ADDR[i]);
      assign hitD = (cpuAddr == PCP_DIR_ADDR[i]);
      assign hitU = (PCP_PU_MASK[i] != 8'h00)
                 && (cpuAddr == PCP_PU_ADDR[i]);
      assign alt  = altOutEn[i*8 +: 8];

      // Write strobes: one register of this port per address
      always_comb begin
         sl.wrLatch = 1'b0;
         sl.wrDir   = 1'b0;
         sl.wrPu    = 1'b0;
         if (cpuWrite) begin
            if (hitL) begin
               sl.wrLatch = 1'b1;
            end else if (hitD) begin
               sl.wrDir = 1'b1;
            end else if (hitU) begin
               sl.wrPu = 1'b1;
            end
         end
      end

      // Bit writes rebuild the whole byte from the read value, so
      // input-mode bits of a mixed port pick up their pin levels
      always_comb begin
         if (!cpuBitOp) begin
            sl.wdata = cpuWdata;
         end else if (hitL) begin
            sl.wdata = mergeBit(sl.readMix, cpuBitSel,
                                cpuBitVal);
         end else if (hitD) begin
            sl.wdata = mergeBit(sl.dir, cpuBitSel, cpuBitVal);
         end else begin
            sl.wdata = mergeBit(sl.pu, cpuBitSel, cpuBitVal);
         end
      end
      assign sl.effIn = sl.dir | forceIn[i];
      assign sl.pinIn = pinIn[i*8 +: 8] & ~forceIn[i];

      // Driver on while the effective direction is output
      assign pinOutEnN_d[i*8 +: 8] = sl.effIn;
      // Peripheral takes the data; the driver still follows direction
      assign pinOut_d[i*8 +: 8] = (alt & altOutData[i*8 +: 8])
                                | (~alt & sl.latch);
      // Never pull up a driven, forced or peripheral-owned pin
      assign pullUpEn_d[i*8 +: 8] = sl.pu & sl.effIn
                                  & ~forceIn[i] & ~alt;

      assign latchRd[i] = sl.readMix;
      assign dirRd[i]   = sl.dir;
      assign puRd[i]    = sl.pu;
   end

   // ============================================================
   // Selector and oscillator mode registers
   // ============================================================
   always_comb begin
      analog_digital_pin_select_d    = analog_digital_pin_select_q;
      oscSel_d  = oscSel_q;
      cpuWait_d = 1'b0;
      if (cpuWrite && hitAdpc) begin
         if (cpuBitOp) begin
            analog_digital_pin_select_d = PCP_ANALOG_DIGITAL_PIN_SELECT_W'(mergeBit({5'h00, analog_digital_pin_select_q},
                                          cpuBitSel, cpuBitVal));
         end else begin
            analog_digital_pin_select_d = cpuWdata[PCP_ANALOG_DIGITAL_PIN_SELECT_W-1:0];
         end
         // Stretches the CPU access by one cycle
         cpuWait_d = 1'b1;
      end
      if (cpuWrite && hitOsc) begin
         if (cpuBitOp) begin
            oscSel_d = mergeBit(oscSel_q, cpuBitSel, cpuBitVal)
                     & PCP_OSCSEL_MASK;
         end else begin
            oscSel_d = cpuWdata & PCP_OSCSEL_MASK;
         end
      end
   end

   // ============================================================
   // Read decode
   // ============================================================
   always_comb begin
      cpuRdata_d = cpuRdata_q;
      if (cpuRead) begin
         // Unmapped addresses read as zero
         cpuRdata_d = 8'h00;
         if (hitAdpc) begin
            cpuRdata_d = {5'h00, analog_digital_pin_select_q};
         end else if (hitOsc) begin
            cpuRdata_d = oscSel_q;
         end else begin
            for (int p = 0; p < PCP_NPORT; p++) begin
               if (cpuAddr == PCP_LATCH_ADDR[p]) begin
                  cpuRdata_d = latchRd[p];
               end else if (cpuAddr == PCP_DIR_ADDR[p]) begin
                  cpuRdata_d = dirRd[p];
               end else if (PCP_PU_MASK[p] != 8'h00
                            && cpuAddr == PCP_PU_ADDR[p]) begin
                  cpuRdata_d = puRd[p];
               end
            end
         end
      end
   end

   // ============================================================
   // Registers: selector and oscillator mode
   // ============================================================
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         analog_digital_pin_select_q   <= PCP_ANALOG_DIGITAL_PIN_SELECT_RST;
         oscSel_q <= PCP_OSCSEL_RST;
      end else begin
         analog_digital_pin_select_q   <= analog_digital_pin_select_d;
         oscSel_q <= oscSel_d;
      end
   end

   // ============================================================
   // Registers: CPU response
   // ============================================================
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cpuRdata_q <= 8'h00;
         cpuWait_q  <= 1'b0;
      end else begin
         cpuRdata_q <= cpuRdata_d;
         cpuWait_q  <= cpuWait_d;
      end
   end

   // ============================================================
   // Registers: pins and converter and clock modes
   // ============================================================
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pinOut_q      <= '0;
         pinOutEnN_q   <= '1;
         pullUpEn_q    <= '0;
         analogSel_q   <= '1;
         oscMainMode_q <= 1'b0;
         oscSubMode_q  <= 1'b0;
      end else begin
         pinOut_q      <= pinOut_d;
         pinOutEnN_q   <= pinOutEnN_d;
         pullUpEn_q    <= pullUpEn_d;
         analogSel_q   <= analogSel_d;
         oscMainMode_q <= oscMainMode_d;
         oscSubMode_q  <= oscSubMode_d;
      end
   end

endmodule

// file: verilog/pcp_port_slice.sv
`timescale 1ns/1ps
// ============================================================
// One 8-bit port: latch, direction, pull-up select
// ============================================================
module pcp_port_slice
   import pcp_pkg::*;
#(
   parameter pcp_byte_type PORT_MASK = 8'hff,
   parameter pcp_byte_type PU_MASK   = 8'hff
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Control side
   pcp_slice_if.slice bus
);

   pcp_byte_type latch_q;
   pcp_byte_type latch_d;
   pcp_byte_type dir_q;
   pcp_byte_type dir_d;
   pcp_byte_type pu_q;
   pcp_byte_type pu_d;

   // ============================================================
   // Next values
   // ============================================================
   always_comb begin
      latch_d = latch_q;
      dir_d   = dir_q;
      pu_d    = pu_q;
      // Latch is written in either mode; driver decides the pin
      if (bus.wrLatch) begin
         latch_d = bus.wdata & PORT_MASK;
      end
      if (bus.wrDir) begin
         dir_d = bus.wdata | ~PORT_MASK;
      end
      if (bus.wrPu) begin
         pu_d = bus.wdata & PU_MASK;
      end
   end

   // ============================================================
   // Registers
   // ============================================================
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         latch_q <= PCP_LATCH_RST;
         dir_q   <= PCP_DIR_RST;
         pu_q    <= PCP_PU_RST;
      end else begin
         latch_q <= latch_d;
         dir_q   <= dir_d;
         pu_q    <= pu_d;
      end
   end

   // Input bits show the pin, output bits the latch
   assign bus.readMix = ((bus.effIn & bus.pinIn)
                      | (~bus.effIn & latch_q)) & PORT_MASK;
   assign bus.latch   = latch_q;
   assign bus.dir     = dir_q;
   assign bus.pu      = pu_q;

endmodule
